// file: i2c_cond_detect.sv
`timescale 1ns/1ps
module i2c_cond_detect
    import i2c_status_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Bus pins, asynchronous to sys_clk
    input wire logic scl_pin,
    input wire logic sda_pin,
    // Decoded bus events
    output bus_ev_t ev
);

    logic [1:0] scl_sync_r;
    logic [1:0] sda_sync_r;
    logic scl_old_r;
    logic sda_old_r;
    logic scl_s;
    logic sda_s;
    bus_ev_t ev_nxt;

    assign scl_s = scl_sync_r[1];
    assign sda_s = sda_sync_r[1];

    // ------------------------------------------------------------
    // Conditions: SDA moves while SCL stays high
    // ------------------------------------------------------------
    assign ev_nxt.start = scl_s & scl_old_r & sda_old_r & ~sda_s;
    assign ev_nxt.stop = scl_s & scl_old_r & ~sda_old_r & sda_s;
    assign ev_nxt.scl_rise = scl_s & ~scl_old_r;
    assign ev_nxt.scl_fall = ~scl_s & scl_old_r;
    assign ev_nxt.sda = sda_s;

    // Idle bus is high, so the chain resets high to avoid a false edge.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            scl_sync_r <= 2'h3;
            sda_sync_r <= 2'h3;
            scl_old_r <= 1'b1;
            sda_old_r <= 1'b1;
            ev <= '0;
        end else begin
            scl_sync_r <= {scl_sync_r[0], scl_pin};
            sda_sync_r <= {sda_sync_r[0], sda_pin};
            scl_old_r <= scl_s;
            sda_old_r <= sda_s;
            ev <= ev_nxt;
        end
    end

endmodule : i2c_cond_detect

// file: i2c_peer.sv
`timescale 1ns/1ps
module i2c_peer #(
    parameter int Q = 40
) (
    // Bus lines, released lines show the pull-up level
    output logic scl,
    output logic sda
);
    // ------------------------------------------------------------
    // Bus master model, bit period 4*Q
    // ------------------------------------------------------------
    // The clock stands still between frames; the model never leaves a line floating.
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end

    task automatic start_cond();
        sda = 1'b1;
        #Q;
        scl = 1'b1;
        #Q;
        sda = 1'b0;
        #Q;
        scl = 1'b0;
        #Q;
    endtask : start_cond

    task automatic stop_cond();
        sda = 1'b0;
        #Q;
        scl = 1'b1;
        #Q;
        sda = 1'b1;
        #(2*Q);
    endtask : stop_cond

    task automatic put_bit(input logic b);
        sda = b;
        #Q;
        scl = 1'b1;
        #(2*Q);
        scl = 1'b0;
        #Q;
    endtask : put_bit

    task automatic send_byte(input logic [7:0] d, input logic ack_lvl);
        for (int i = 7; i >= 0; i--) begin
            put_bit(d[i]);
        end
        put_bit(ack_lvl);
        sda = 1'b1;
        #Q;
    endtask : send_byte
endmodule : i2c_peer

// file: i2c_status_cfg.svh
`ifndef I2C_STATUS_CFG_SVH
`define I2C_STATUS_CFG_SVH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define OFS_STATUS 12'h000
`define OFS_CTRL 12'h004
`define OFS_BUFFER 12'h008
`define OFS_SLV_ADDR 12'h00C
`define OFS_INT_STAT 12'h010
`define OFS_INT_MASK 12'h014

// ------------------------------------------------------------
// Status flag positions
// ------------------------------------------------------------
`define ST_SMBUS 6
`define ST_DATA 5
`define ST_STOP 4
`define ST_START 3
`define ST_RW 2
`define ST_UA 1
`define ST_BF 0

// ------------------------------------------------------------
// Control positions, interrupt positions, reset values
// ------------------------------------------------------------
`define CT_PORT_EN 0
`define CT_SMBUS 1
`define CT_MASTER 2
`define CT_TEN_BIT 3
`define IN_START 0
`define IN_STOP 1
`define IN_BYTE 2
`define IN_MATCH 3
`define CTRL_RST 4'h0
`define SLV_ADDR_RST 8'h00
`define MASK_RST 4'h0

`endif

// file: i2c_status_flags.sv
// Design decisions made here: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
`include "i2c_status_cfg.svh"

module i2c_status_flags
    import i2c_status_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Bus pins
    input wire logic scl_pin,
    input wire logic sda_pin,
    // Master sequence generator state
    input wire logic master_tx_busy,
    input wire logic start_cond_enable,
    input wire logic repeated_start_enable,
    input wire logic stop_cond_enable,
    input wire logic receive_sequence_enable,
    input wire logic ack_sequence_enable,
    // Outputs
    output logic smbus_thresh_en,
    output logic port_active,
    output logic irq
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    bus_ev_t ev;
    ctrl_t ctrl_r;
    addr_st_t st_r;
    addr_st_t st_nxt;
    logic [7:0] slave_address_reg_r;
    logic [7:0] serial_shift_buffer_r;
    logic [7:0] shift_r;
    logic [3:0] bit_cnt_r;
    logic [3:0] int_stat_r;
    logic [3:0] int_mask_r;
    logic [3:0] int_ev;
    logic [11:0] wr_addr_r;
    logic wr_pend_r;
    logic start_seen_r;
    logic stop_seen_r;
    logic data_flag_r;
    logic rw_r;
    logic address_update_flag_r;
    logic buffer_full_flag_r;
    logic hi_ok_r;
    logic [7:0] byte_val;
    logic byte_done;
    logic ack_bit;
    logic nack;
    logic slave_mode;
    logic match_ev;
    logic match_rw;
    logic addr_byte;
    logic ua_set;
    logic rx_fill;
    logic tx_sent;
    logic buf_wr;
    logic buf_rd;
    logic rw_show;
    logic [7:0] status_word;
    logic [31:0] rd_word;
    logic [11:0] rd_addr;
    logic rd_take;
    logic wr_take;

    function automatic logic is_reg(input logic [11:0] a, input logic [11:0] ofs);
        is_reg = (a == ofs);
    endfunction : is_reg

    i2c_cond_detect u_detect (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .scl_pin(scl_pin),
        .sda_pin(sda_pin),
        .ev(ev)
    );

    // ------------------------------------------------------------
    // AHB-Lite access decode
    // ------------------------------------------------------------
    // Zero wait states: reads are served from flops set up in the
    // address phase, writes land at the end of the data phase.
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign rd_addr = haddr[11:0];
    assign rd_take = hsel & hready & htrans[1] & ~hwrite;
    assign wr_take = hsel & hready & htrans[1] & hwrite;
    assign buf_wr = wr_pend_r & is_reg(wr_addr_r, `OFS_BUFFER);
    assign buf_rd = rd_take & is_reg(rd_addr, `OFS_BUFFER);

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 12'h000;
        end else begin
            wr_pend_r <= wr_take;
            wr_addr_r <= rd_addr;
        end
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_r <= `CTRL_RST;
            slave_address_reg_r <= `SLV_ADDR_RST;
            int_mask_r <= `MASK_RST;
        end else if (wr_pend_r) begin
            if (is_reg(wr_addr_r, `OFS_CTRL))
                ctrl_r <= hwdata[3:0];
            if (is_reg(wr_addr_r, `OFS_SLV_ADDR))
                slave_address_reg_r <= hwdata[7:0];
            if (is_reg(wr_addr_r, `OFS_INT_MASK))
                int_mask_r <= hwdata[3:0];
        end
    end

    assign smbus_thresh_en = ctrl_r.smbus_sel;
    assign slave_mode = ctrl_r.port_en & ~ctrl_r.master_mode;
    assign port_active = master_tx_busy | start_cond_enable | repeated_start_enable |
                         stop_cond_enable | receive_sequence_enable |
                         ack_sequence_enable;

    // ------------------------------------------------------------
    // Bit counter and shifter
    // ------------------------------------------------------------
    // Bits are sampled on SCL rise; the ninth rise is the ack slot.
    assign byte_val = {shift_r[6:0], ev.sda};
    assign byte_done = ev.scl_rise & (bit_cnt_r == 4'h7);
    assign ack_bit = ev.scl_rise & (bit_cnt_r == 4'h8);
    assign nack = ack_bit & ev.sda;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            bit_cnt_r <= 4'h0;
            shift_r <= 8'h00;
        end else if (ev.start | ev.stop | ~ctrl_r.port_en) begin
            bit_cnt_r <= 4'h0;
        end else if (ev.scl_rise) begin
            shift_r <= byte_val;
            bit_cnt_r <= ack_bit ? 4'h0 : bit_cnt_r + 4'h1;
        end
    end

    // ------------------------------------------------------------
    // Slave address recognition
    // ------------------------------------------------------------
    // Ten-bit: the first byte carries the high part, the second the
    // low part; a repeated Start with the high part and R/W set
    // re-addresses for reading a slave already matched.
    always_comb begin
        st_nxt = st_r;
        match_ev = 1'b0;
        match_rw = 1'b0;
        addr_byte = 1'b0;
        ua_set = 1'b0;
        if (!slave_mode || ev.stop) begin
            st_nxt = ADDR_IDLE;
        end else if (ev.start) begin
            st_nxt = ADDR_FIRST;
        end else if (byte_done) begin
            case (st_r)
                ADDR_FIRST: begin
                    addr_byte = 1'b1;
                    if (!ctrl_r.ten_bit) begin
                        if (byte_val[7:1] == slave_address_reg_r[6:0]) begin
                            st_nxt = ADDR_MATCHED;
                            match_ev = 1'b1;
                            match_rw = byte_val[0];
                        end else begin
                            st_nxt = ADDR_SKIP;
                        end
                    end else if (byte_val[7:1] == slave_address_reg_r[7:1]) begin
                        if (byte_val[0] && hi_ok_r) begin
                            st_nxt = ADDR_MATCHED;
                            match_ev = 1'b1;
                            match_rw = 1'b1;
                        end else begin
                            st_nxt = ADDR_LOW;
                            ua_set = 1'b1;
                        end
                    end else begin
                        st_nxt = ADDR_SKIP;
                    end
                end
                ADDR_LOW: begin
                    addr_byte = 1'b1;
                    if (byte_val == slave_address_reg_r) begin
                        st_nxt = ADDR_MATCHED;
                        match_ev = 1'b1;
                        ua_set = 1'b1;
                    end else begin
                        st_nxt = ADDR_SKIP;
                    end
                end
                default: begin
                    st_nxt = st_r;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            st_r <= ADDR_IDLE;
            hi_ok_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            if (!slave_mode || ev.stop)
                hi_ok_r <= 1'b0;
            else if (match_ev && ctrl_r.ten_bit)
                hi_ok_r <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Condition, data and direction flags
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            start_seen_r <= 1'b0;
            stop_seen_r <= 1'b0;
        end else if (!ctrl_r.port_en) begin
            start_seen_r <= 1'b0;
            stop_seen_r <= 1'b0;
        end else if (ev.start) begin
            start_seen_r <= 1'b1;
            stop_seen_r <= 1'b0;
        end else if (ev.stop) begin
            start_seen_r <= 1'b0;
            stop_seen_r <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            data_flag_r <= 1'b0;
            rw_r <= 1'b0;
        end else if (!slave_mode) begin
            data_flag_r <= 1'b0;
            rw_r <= 1'b0;
        end else begin
            if (addr_byte)
                data_flag_r <= 1'b0;
            else if (byte_done && st_r == ADDR_MATCHED)
                data_flag_r <= 1'b1;
            if (match_ev)
                rw_r <= match_rw;
            else if (ev.start || ev.stop || nack)
                rw_r <= 1'b0;
        end
    end

    assign rw_show = ctrl_r.master_mode ? master_tx_busy : rw_r;

    // ------------------------------------------------------------
    // Address update and buffer full
    // ------------------------------------------------------------
    // Set wins over clear so a late bus event is never dropped.
    assign rx_fill = byte_done & ((slave_mode & st_r == ADDR_MATCHED & ~rw_r) |
                     (ctrl_r.master_mode & receive_sequence_enable));
    assign tx_sent = byte_done & ((slave_mode & st_r == ADDR_MATCHED & rw_r) |
                     (ctrl_r.master_mode & master_tx_busy));

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            address_update_flag_r <= 1'b0;
            buffer_full_flag_r <= 1'b0;
            serial_shift_buffer_r <= 8'h00;
        end else begin
            if (ua_set && ctrl_r.ten_bit)
                address_update_flag_r <= 1'b1;
            else if (!ctrl_r.ten_bit || (wr_pend_r && is_reg(wr_addr_r, `OFS_SLV_ADDR)))
                address_update_flag_r <= 1'b0;
            if (rx_fill || buf_wr)
                buffer_full_flag_r <= 1'b1;
            else if (tx_sent || buf_rd || !ctrl_r.port_en)
                buffer_full_flag_r <= 1'b0;
            if (rx_fill)
                serial_shift_buffer_r <= byte_val;
            else if (buf_wr)
                serial_shift_buffer_r <= hwdata[7:0];
        end
    end

    // ------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------
    assign int_ev = {match_ev, byte_done & ctrl_r.port_en,
                     ev.stop & ctrl_r.port_en, ev.start & ctrl_r.port_en};

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn)
            int_stat_r <= 4'h0;
        else if (wr_pend_r && is_reg(wr_addr_r, `OFS_INT_STAT))
            int_stat_r <= (int_stat_r & ~hwdata[3:0]) | int_ev;
        else
            int_stat_r <= int_stat_r | int_ev;
    end

    assign irq = |(int_stat_r & int_mask_r);

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    // The status word has no write path of its own, so a write to its
    // offset cannot disturb the flags.
    assign status_word = {1'b0, ctrl_r.smbus_sel, data_flag_r, stop_seen_r,
                          start_seen_r, rw_show, address_update_flag_r,
                          buffer_full_flag_r};
    assign rd_word = is_reg(rd_addr, `OFS_STATUS) ? {24'h000000, status_word} :
                     is_reg(rd_addr, `OFS_CTRL) ? {28'h0000000, ctrl_r} :
                     is_reg(rd_addr, `OFS_BUFFER) ? {24'h000000, serial_shift_buffer_r} :
                     is_reg(rd_addr, `OFS_SLV_ADDR) ? {24'h000000, slave_address_reg_r} :
                     is_reg(rd_addr, `OFS_INT_STAT) ? {28'h0000000, int_stat_r} :
                     is_reg(rd_addr, `OFS_INT_MASK) ? {28'h0000000, int_mask_r} :
                     32'h00000000;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn)
            hrdata <= 32'h00000000;
        else if (rd_take)
            hrdata <= rd_word;
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    sequence seq_ctrl_write;
        wr_pend_r && is_reg(wr_addr_r, `OFS_CTRL);
    endsequence

    sequence seq_addr_match;
        match_ev && slave_mode;
    endsequence

    chk_smbus_follow: assert property (seq_ctrl_write |=>
        smbus_thresh_en == $past(hwdata[`CT_SMBUS]))
        else $error("SMBus threshold enable does not follow control write");

    chk_data_flag: assert property (byte_done && st_r == ADDR_MATCHED && slave_mode
        |=> data_flag_r)
        else $error("Data flag not set after data byte");

    chk_stop_flag: assert property (ev.stop && ctrl_r.port_en |=>
        stop_seen_r && !start_seen_r)
        else $error("Stop flag wrong after Stop");

    chk_start_flag: assert property (ev.start && ctrl_r.port_en |=>
        start_seen_r && !stop_seen_r)
        else $error("Start flag wrong after Start");

    chk_disable_clear: assert property (!ctrl_r.port_en |=>
        !start_seen_r && !stop_seen_r)
        else $error("Condition flags survive port disable");

    chk_rw_capture: assert property (seq_addr_match |=>
        rw_r == $past(match_rw))
        else $error("Direction not captured on address match");

    chk_rw_drop: assert property (slave_mode && !match_ev &&
        (ev.start || ev.stop || nack) |=> !rw_r)
        else $error("Direction still valid after Start, Stop or NACK");

    chk_master_rw: assert property (ctrl_r.master_mode |->
        status_word[`ST_RW] == master_tx_busy)
        else $error("Master direction flag does not show transmit busy");

    chk_ua_set: assert property (ua_set && ctrl_r.ten_bit |=>
        address_update_flag_r)
        else $error("Address update flag not raised");

    chk_bf_tx: assert property (tx_sent && !buf_wr && !rx_fill |=> !buffer_full_flag_r)
        else $error("Buffer full stays set after byte sent");

    chk_bf_rx: assert property (rx_fill |=> buffer_full_flag_r ##0
        serial_shift_buffer_r == $past(byte_val))
        else $error("Received byte not latched as full");

    chk_status_ro: assert property (wr_pend_r && is_reg(wr_addr_r, `OFS_STATUS)
        && !ev.start && !ev.stop && ctrl_r.port_en |=> $stable(start_seen_r)
        && $stable(stop_seen_r))
        else $error("Status write changed condition flags");

endmodule : i2c_status_flags

// file: i2c_status_flags_bench.sv
`timescale 1ns/1ps
`include "i2c_status_cfg.svh"
module i2c_status_flags_bench;
    import i2c_status_pkg::*;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [5:0] seq_in = 6'h00;
    wire hreadyout, hresp, smbus_thresh_en, port_active, irq, scl, sda;
    wire [31:0] hrdata;
    int errors = 0;
    int n_compared = 0;
    logic [31:0] rd;
    logic [7:0] dbyte;

    always #4 sys_clk = ~sys_clk;

    i2c_status_flags i2c_status_flags_i (.sys_clk(sys_clk), .resetn(resetn), .hsel(1'b1),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .scl_pin(scl), .sda_pin(sda), .master_tx_busy(seq_in[5]),
        .start_cond_enable(seq_in[4]), .repeated_start_enable(seq_in[3]),
        .stop_cond_enable(seq_in[2]), .receive_sequence_enable(seq_in[1]),
        .ack_sequence_enable(seq_in[0]), .smbus_thresh_en(smbus_thresh_en),
        .port_active(port_active), .irq(irq));

    i2c_peer i2c_peer_i (.scl(scl), .sda(sda));

    // ------------------------------------------------------------
    // Shared tasks and expectations
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] r);
        @(posedge sys_clk);
        haddr <= {20'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        @(posedge sys_clk);
        while (hreadyout !== 1'b1) @(posedge sys_clk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge sys_clk);
        while (hreadyout !== 1'b1) @(posedge sys_clk);
        r = hrdata;
    endtask : xfer

    function automatic logic [31:0] st(input logic s, p, d, rw, bf);
        st = 32'h0;
        st[`ST_START] = s;
        st[`ST_STOP] = p;
        st[`ST_DATA] = d;
        st[`ST_RW] = rw;
        st[`ST_BF] = bf;
    endfunction : st

    task automatic tally_and_finish();
        $display("compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : tally_and_finish

    // ------------------------------------------------------------
    // Watchdog at 25000 cycles, well beyond the roughly 1500 cycles the run needs
    // ------------------------------------------------------------
    initial begin
        #200000;
        errors++;
        tally_and_finish();
    end

    initial begin
        void'($urandom(32'h6970e359));
        repeat (2) @(posedge sys_clk);
        resetn <= 1'b1;
        xfer(0, `OFS_STATUS, 0, rd);
        check(rd, 32'h0);
        check(hresp, 1'b0);
        xfer(1, `OFS_STATUS, 32'h7F, rd);
        xfer(0, `OFS_STATUS, 0, rd);
        check(rd, 32'h0);
        xfer(0, 12'h0FC, 0, rd);
        check(rd, 32'h0);
        $display("test reset done");
        repeat (24) begin
            @(posedge sys_clk);
            seq_in <= 6'($urandom);
            @(posedge sys_clk);
            check(port_active, |seq_in);
        end
        seq_in <= 6'h00;
        @(posedge sys_clk);
        check(port_active, 1'b0);
        $display("test active done");
        xfer(1, `OFS_CTRL, 32'h2, rd);
        xfer(0, `OFS_STATUS, 0, rd);
        check(rd[`ST_SMBUS], 1'b1);
        check(smbus_thresh_en, 1'b1);
        xfer(1, `OFS_CTRL, 32'h0, rd);
        repeat (2) @(posedge sys_clk);
        check(smbus_thresh_en, 1'b0);
        i2c_peer_i.start_cond();
        xfer(0, `OFS_STATUS, 0, rd);
        check(rd[`ST_START], 1'b0);
        i2c_peer_i.stop_cond();
        $display("test select done");
        // Slave write: address, then one random data byte.
        dbyte = 8'($urandom);
        xfer(1, `OFS_CTRL, 32'h1, rd);
        xfer(1, `OFS_SLV_ADDR, 32'h2A, rd);
        i2c_peer_i.start_cond();
        xfer(0, `OFS_STATUS, 0, rd);
        check(rd, st(1, 0, 0, 0, 0));
        i2c_peer_i.send_byte({7'h2A, 1'b0}, 1'b0);
        xfer(0, `OFS_STATUS, 0, rd);
        check(rd, st(1, 0, 0, 0, 0));
        i2c_peer_i.send_byte(dbyte, 1'b0);
        xfer(0, `OFS_STATUS, 0, rd);
        check(rd, st(1, 0, 1, 0, 1));
        xfer(0, `OFS_BUFFER, 0, rd);
        check(rd, {24'h0, dbyte});
        xfer(0, `OFS_STATUS, 0, rd);
        check(rd[`ST_BF], 1'b0);
        i2c_peer_i.stop_cond();
        xfer(0, `OFS_STATUS, 0, rd);
        check(rd[`ST_STOP], 1'b1);
        check(rd[`ST_START], 1'b0);
        $display("test slave write done");
        // Slave read ended by a not-acknowledge from the master.
        i2c_peer_i.start_cond();
        xfer(0, `OFS_STATUS, 0, rd);
        check(rd[`ST_STOP], 1'b0);
        i2c_peer_i.send_byte({7'h2A, 1'b1}, 1'b0);
        xfer(0, `OFS_STATUS, 0, rd);
        check(rd, st(1, 0, 0, 1, 0));
        xfer(1, `OFS_BUFFER, {24'h0, dbyte}, rd);
        xfer(0, `OFS_STATUS, 0, rd);
        check(rd[`ST_BF], 1'b1);
        i2c_peer_i.send_byte(dbyte, 1'b1);
        xfer(0, `OFS_STATUS, 0, rd);
        check(rd, st(1, 0, 1, 0, 0));
        i2c_peer_i.stop_cond();
        $display("test slave read done");
        xfer(0, `OFS_INT_STAT, 0, rd);
        check(rd[`IN_START], 1'b1);
        xfer(1, `OFS_INT_MASK, 32'h0, rd);
        @(posedge sys_clk);
        check(irq, 1'b0);
        xfer(1, `OFS_INT_MASK, 32'h1 << `IN_STOP, rd);
        @(posedge sys_clk);
        check(irq, 1'b1);
        xfer(1, `OFS_INT_STAT, 32'hF, rd);
        @(posedge sys_clk);
        check(irq, 1'b0);
        $display("test interrupt done");
        xfer(1, `OFS_CTRL, 32'h9, rd);
        xfer(1, `OFS_SLV_ADDR, 32'hF0, rd);
        i2c_peer_i.start_cond();
        i2c_peer_i.send_byte(8'hF0, 1'b0);
        xfer(0, `OFS_STATUS, 0, rd);
        check(rd[`ST_UA], 1'b1);
        xfer(1, `OFS_SLV_ADDR, 32'hF0, rd);
        xfer(0, `OFS_STATUS, 0, rd);
        check(rd[`ST_UA], 1'b0);
        i2c_peer_i.send_byte(8'hF0, 1'b0);
        xfer(0, `OFS_STATUS, 0, rd);
        check(rd[`ST_UA], 1'b1);
        i2c_peer_i.stop_cond();
        xfer(1, `OFS_CTRL, 32'h0, rd);
        xfer(0, `OFS_STATUS, 0, rd);
        check(rd[`ST_STOP], 1'b0);
        $display("test ten bit done");
        xfer(1, `OFS_CTRL, 32'h5, rd);
        seq_in <= 6'h20;
        xfer(0, `OFS_STATUS, 0, rd);
        check(rd[`ST_RW], 1'b1);
        seq_in <= 6'h00;
        xfer(0, `OFS_STATUS, 0, rd);
        check(rd[`ST_RW], 1'b0);
        $display("test master done");
        tally_and_finish();
    end
endmodule : i2c_status_flags_bench

// file: i2c_status_pkg.sv
package i2c_status_pkg;

    typedef struct packed {
        logic start;
        logic stop;
        logic scl_rise;
        logic scl_fall;
        logic sda;
    } bus_ev_t;

    typedef struct packed {
        logic ten_bit;
        logic master_mode;
        logic smbus_sel;
        logic port_en;
    } ctrl_t;

    typedef enum logic [2:0] {
        ADDR_IDLE,
        ADDR_FIRST,
        ADDR_LOW,
        ADDR_MATCHED,
        ADDR_SKIP
    } addr_st_t;

endpackage : i2c_status_pkg
